// ==== core/swdt_defs.svh ====
// constants for the supervision timer: register addresses, keys, field positions, dividers
// assumes the including file uses the names below and nothing else from it
//
// Operation
// - 8-bit readable, writable up-counter, one step per selected count-clock pulse when running.
// - overflow raises a reset in watchdog mode, an interrupt request in interval mode.
// - counter cleared to zero only by the external power-on reset.
// - counter write is 16 bits with key 5A high; low byte is stored.
// - control/status write is 16 bits with key A5 high; low byte is stored.
// - byte and 32-bit writes to either register are refused.
// - control/status cleared only by power-on reset; kept across the timer's own reset.
// - control/status keeps its contents after a standby stabilisation overflow.
// - bit 7 runs the count; at zero the count holds; reset value zero.
// - bit 6 selects mode: zero interval, one watchdog; reset is interval.
// - bit 5 picks power-on or manual reset on watchdog overflow only.
// - bit 4 set on watchdog-mode overflow, never in interval mode.
// - bit 3 set on interval-mode overflow, never in watchdog mode.
// - bits 2..0 select input clock divided by 32 up to 4096; reset is 32.
// - after a first PLL switch the count clock follows the new clock.
// - counter keeps counting after an overflow in either mode.
// - interval overflow sends an interval request to the interrupt controller.
`ifndef SWDT_DEFS_SVH
`define SWDT_DEFS_SVH

`define SWDT_ADDR_COUNT    32'hFFC00008
`define SWDT_ADDR_CTRL     32'hFFC0000C
`define SWDT_ADDR_MASK     32'h1FFFFFFF
`define SWDT_KEY_COUNT     8'h5A
`define SWDT_KEY_CTRL      8'hA5
`define SWDT_RESET_VALUE   8'h00
`define SWDT_COUNT_MAX     8'hFF
`define SWDT_BIT_RUN       7
`define SWDT_BIT_MODE      6
`define SWDT_BIT_RKIND     5
`define SWDT_BIT_WATCHDOG_OVERFLOW_FLAG      4
`define SWDT_BIT_INTERVAL_OVERFLOW_FLAG      3
`define SWDT_CKS_HI        2
`define SWDT_DIV_BASE_LOG2 5
`define SWDT_PRE_WIDTH     12

`endif

// ==== core/swdt_pkg.sv ====
// types for the supervision timer
// assumes swdt_defs.svh is compiled alongside
package swdt_pkg;

  // bus access size as presented by the processor bus
  typedef enum logic [2:0] {
    SWDT_SIZE_BYTE = 3'b001,
    SWDT_SIZE_WORD = 3'b010,
    SWDT_SIZE_LONG = 3'b100
  } swdt_size_t;

  typedef struct packed {
    logic       run;
    logic       mode;
    logic       rkind;
    logic       watchdog_overflow_flag;
    logic       interval_overflow_flag;
    logic [2:0] cks;
  } swdt_ctrl_t;

  typedef struct packed {
    logic [11:0] pre;
    logic        tick_src_q;
    logic [7:0]  count;
    swdt_ctrl_t  ctrl;
    logic [7:0]  rdata;
    logic        por_req;
    logic        man_req;
    logic        irq;
  } swdt_state_t;

endpackage

// ==== core/swdt_timer.sv ====
// supervision timer: keyed 8-bit counter and control/status register
// assumes i_clk_in is the clock generator input clock already muxed after any
// first_pll switch, and that the bus presents one-cycle strobes on i_clk
`timescale 1ns/1ns
`include "swdt_defs.svh"
module swdt_timer
  import swdt_pkg::*;
#(
  parameter int PRE_WIDTH = `SWDT_PRE_WIDTH
) (
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_clk_in_tick,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [31:0] i_addr,
  input  wire swdt_size_t  i_size,
  input  wire logic [15:0] i_wdata,
  output logic [7:0]       o_rdata,
  output logic             o_por_req,
  output logic             o_man_req,
  output logic             o_irq
);

  // --------------------------------------------------------------------
  // reset release
  // --------------------------------------------------------------------
  logic [1:0] rst_sync;
  logic       rst_n;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // --------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------
  // both the P4 and the area-7 images decode, so the top three bits are masked
  function automatic logic addr_hit(input logic [31:0] a, input logic [31:0] reg_addr);
    addr_hit = ((a & `SWDT_ADDR_MASK) == (reg_addr & `SWDT_ADDR_MASK));
  endfunction

  swdt_state_t state;
  swdt_state_t next_state;

  logic       hit_count;
  logic       hit_ctrl;
  logic       wr_count;
  logic       wr_ctrl;
  logic       step;
  logic       ovf;
  logic [PRE_WIDTH-1:0] next_pre;

  assign hit_count = addr_hit(i_addr, `SWDT_ADDR_COUNT);
  assign hit_ctrl  = addr_hit(i_addr, `SWDT_ADDR_CTRL);
  // byte and long writes, and wrong keys, are dropped silently
  assign wr_count = i_wr && hit_count && (i_size == SWDT_SIZE_WORD)
                    && (i_wdata[15:8] == `SWDT_KEY_COUNT);
  assign wr_ctrl  = i_wr && hit_ctrl && (i_size == SWDT_SIZE_WORD)
                    && (i_wdata[15:8] == `SWDT_KEY_CTRL);

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  always_comb begin
    next_state         = state;
    next_state.por_req = 1'b0;
    next_state.man_req = 1'b0;
    next_state.irq     = 1'b0;
    // prescaler runs only while counting and keeps its phase while stopped
    next_pre = state.pre[PRE_WIDTH-1:0];
    if (state.ctrl.run && i_clk_in_tick) begin
      next_pre = state.pre[PRE_WIDTH-1:0] + 1'b1;
    end
    next_state.pre = next_pre;
    // divide tap: code 0 is bit 4 (1/32), code 7 is bit 11 (1/4096)
    next_state.tick_src_q =
      next_pre[(`SWDT_DIV_BASE_LOG2 - 1) + state.ctrl.cks];
    step = state.ctrl.run && state.tick_src_q && !next_state.tick_src_q;
    ovf  = step && (state.count == `SWDT_COUNT_MAX);

    if (wr_count) begin
      next_state.count = i_wdata[7:0];
    end else if (step) begin
      next_state.count = state.count + 8'h01;
    end

    if (wr_ctrl) begin
      next_state.ctrl = swdt_ctrl_t'(i_wdata[7:0]);
    end
    if (ovf) begin
      if (state.ctrl.mode) begin
        next_state.ctrl.watchdog_overflow_flag = 1'b1;
        next_state.por_req   = !state.ctrl.rkind;
        next_state.man_req   = state.ctrl.rkind;
      end else begin
        next_state.ctrl.interval_overflow_flag = 1'b1;
        next_state.irq       = 1'b1;
      end
    end

    if (i_rd && hit_count) begin
      next_state.rdata = state.count;
    end else if (i_rd && hit_ctrl) begin
      next_state.rdata = state.ctrl;
    end else if (i_rd) begin
      next_state.rdata = `SWDT_RESET_VALUE;
    end
  end

  // --------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------
  // the pin reset is the only thing that clears count and control; a reset
  // raised by this timer never loops back here, so contents survive it
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign o_rdata   = state.rdata;
  assign o_por_req = state.por_req;
  assign o_man_req = state.man_req;
  assign o_irq     = state.irq;

endmodule

// ==== test/swdt_assertions.sv ====
// port-level checks of the supervision timer
// assumes bind onto swdt_timer, one clock, active-low reset
`timescale 1ns/1ns
module swdt_assertions
  import swdt_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_arst_n,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] i_addr,
  input wire swdt_size_t  i_size,
  input wire logic [15:0] i_wdata,
  input wire logic [7:0]  o_rdata,
  input wire logic        o_por_req,
  input wire logic        o_man_req,
  input wire logic        o_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  logic       hit_n;
  logic       hit_c;
  logic [7:0] wlo;
  assign hit_n = i_addr[28:0] == 29'h1FC00008;
  assign hit_c = i_addr[28:0] == 29'h1FC0000C;
  assign wlo   = i_wdata[7:0];
  sequence s_wr_c; i_wr && i_size == SWDT_SIZE_WORD && hit_c && i_wdata[15:8] == 8'hA5; endsequence
  sequence s_wr_n; i_wr && i_size == SWDT_SIZE_WORD && hit_n && i_wdata[15:8] == 8'h5A; endsequence
  // flags are masked: an overflow may set one between write and read
  AST_CTRL_WR: assert property (s_wr_c ##1 !i_wr ##1 (i_rd && hit_c && !i_wr) |=>
    (o_rdata & 8'hE7) == ($past(wlo, 3) & 8'hE7)) else $error("control write lost");
  AST_CNT_WR: assert property (s_wr_n ##1 !i_wr ##1 (i_rd && hit_n && !i_wr) |=>
    8'(o_rdata - $past(wlo, 3)) <= 8'h01) else $error("count write lost");
  AST_REQ_EXCL: assert property (!(o_irq && (o_por_req || o_man_req)))
    else $error("interrupt and reset together");
  AST_KIND_EXCL: assert property (!(o_por_req && o_man_req)) else $error("two reset kinds");
  AST_IRQ_PULSE: assert property (o_irq |=> !o_irq [*8]) else $error("irq too long");
  AST_POR_PULSE: assert property ($rose(o_por_req) |=> $fell(o_por_req)) else $error("por long");
  AST_RD_HOLD: assert property (!$past(i_rd) |-> $stable(o_rdata)) else $error("rdata moved");
  AST_UNMAPPED: assert property (i_rd && !hit_n && !hit_c |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind swdt_timer swdt_assertions i_chk (.*);

// ==== test/swdt_timer_tb_top.sv ====
// self-checking bench of the supervision timer
// assumes a 100 MHz clock and a clock-generator tick every cycle
`timescale 1ns/1ns
`include "swdt_defs.svh"
module swdt_timer_tb_top;
  import swdt_pkg::*;
  logic i_clk = 0, i_arst_n = 0, i_tick = 1, i_wr = 0, i_rd = 0, o_por_req, o_man_req, o_irq;
  logic [31:0] i_addr = 0;
  logic [15:0] i_wdata = 0;
  logic [7:0]  o_rdata, v, c, r;
  swdt_size_t  i_size = SWDT_SIZE_WORD;
  int          miscompares = 0, n_tests = 0, seed = 32'h0d039d6d, t;
  always #5 i_clk = ~i_clk;
  swdt_timer i_dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_clk_in_tick(i_tick), .i_wr(i_wr),
    .i_rd(i_rd), .i_addr(i_addr), .i_size(i_size), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .o_por_req(o_por_req), .o_man_req(o_man_req), .o_irq(o_irq));
  task report_and_stop;
    if (miscompares == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task wr(input logic [31:0] a, input logic [15:0] d, input swdt_size_t s = SWDT_SIZE_WORD);
    @(posedge i_clk);
    {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
    i_size <= s;
    @(posedge i_clk);
    i_wr <= 0;
  endtask
  task rd(input logic [31:0] a, input logic [7:0] e);
    @(posedge i_clk);
    {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_clk);
    i_rd <= 0;
    @(posedge i_clk);
    #1 chk(o_rdata, e);
  endtask
  // waits for any request, counting edges; the bound covers two slowest steps
  task wt(output int n);
    n = 0;
    do begin
      @(posedge i_clk);
      #1 n++;
      if (n > 9000) begin
        miscompares++;
        report_and_stop;
      end
    end while (!(o_irq | o_por_req | o_man_req));
    r = {5'h00, o_por_req, o_man_req, o_irq};
  endtask
  function logic [7:0] req_of(input logic [7:0] k);
    return k[6] ? (k[5] ? 8'h02 : 8'h04) : 8'h01;
  endfunction
  initial begin
    repeat (10) @(posedge i_clk);
    i_arst_n <= 1;
    repeat (3) @(posedge i_clk);
    rd(`SWDT_ADDR_COUNT, 8'h00);
    rd(`SWDT_ADDR_CTRL, 8'h00);
    rd(32'hFFC00004, 8'h00);
    repeat (12) begin
      v = 8'($random(seed));
      wr(`SWDT_ADDR_COUNT, {8'h5A, v});
      rd(32'h1FC00008, v);
      wr(`SWDT_ADDR_COUNT, {8'h5A ^ (8'($random(seed)) | 8'h01), ~v});
      wr(`SWDT_ADDR_COUNT, {8'h5A, ~v}, SWDT_SIZE_BYTE);
      wr(`SWDT_ADDR_COUNT, {8'h5A, ~v}, SWDT_SIZE_LONG);
      wr(`SWDT_ADDR_CTRL, {8'h5A, 8'h80});
      repeat (40) @(posedge i_clk);
      rd(`SWDT_ADDR_COUNT, v);
    end
    for (int k = 0; k < 10; k++) begin
      c = (k < 8) ? (8'h80 | 8'(k)) : (8'hC0 | ((8'(k) - 8'h08) << 5));
      // stop before touching mode or clock select
      wr(`SWDT_ADDR_CTRL, {8'hA5, 8'h00});
      wr(`SWDT_ADDR_COUNT, {8'h5A, 8'hFE});
      wr(`SWDT_ADDR_CTRL, {8'hA5, c});
      rd(`SWDT_ADDR_CTRL, c);
      wt(t);
      wr(`SWDT_ADDR_COUNT, {8'h5A, 8'hFF});
      wt(t);
      chk(8'((t + 2) >> 5), 8'h01 << c[2:0]);
      chk(r, req_of(c));
      rd(`SWDT_ADDR_COUNT, 8'h00);
      rd(`SWDT_ADDR_CTRL, c | (c[6] ? 8'h10 : 8'h08));
      repeat (32 << c[2:0]) @(posedge i_clk);
      rd(`SWDT_ADDR_COUNT, 8'h01);
    end
    report_and_stop;
  end
endmodule
